// file: design/fieldbus_assembly_io_map.sv
// Assembly parser, configuration capture and switching channel object
`default_nettype none
module fieldbus_assembly_io_map (
    input  wire logic        i_clk,          // 200 MHz system clock
    input  wire logic        i_rstn,         // Async reset, active low
    input  wire logic        i_asm_valid,    // Entry assembly byte strobe
    input  wire logic        i_asm_sof,      // Marks byte 0 of a frame
    input  wire logic [7:0]  i_asm_byte,     // Entry assembly byte
    input  wire logic        i_cfg_valid,    // Configuration byte strobe
    input  wire logic        i_cfg_sof,      // Marks config byte 0
    input  wire logic        i_cfg_last,     // Marks last config byte
    input  wire logic [7:0]  i_cfg_byte,     // Configuration byte
    input  wire logic        i_conn_setup,   // Connection being set up
    input  wire logic        i_req_valid,    // Object service request
    input  wire logic [7:0]  i_req_service,  // Service code
    input  wire logic [7:0]  i_req_class,    // Object class
    input  wire logic [7:0]  i_req_inst,     // Instance
    input  wire logic [7:0]  i_req_attr,     // Attribute
    input  wire logic [7:0]  i_req_wdata,    // Set value
    input  wire logic [3:0]  i_sw_state,     // Switching pin states
    input  wire logic [3:0]  i_sw_event,     // Activation event pulses
    input  wire logic [3:0]  i_multi_mode,   // Multi-switch compare mode
    input  wire logic [15:0] i_cmp_value,    // Comparison value
    output logic [7:0]       o_frag_num,     // Fragment number
    output logic [7:0]       o_frag_remain,  // Remaining fragments
    output logic [7:0]       o_frag_size,    // Fragment size
    output logic             o_new_data,     // New-data flag
    output logic             o_new_entry,    // Toggle edge seen, pulse
    output logic [15:0]      o_entry_len,    // Entry data length
    output logic             o_entry_valid,  // Payload byte strobe
    output logic [7:0]       o_entry_data,   // Payload byte
    output logic [7:0]       o_entry_index,  // Payload byte index
    output logic             o_asm_overrun,  // Frame beyond 261 bytes
    output logic [7:0]       o_handshake_cfg, // Config byte 0
    output logic [7:0]       o_result_frag_cfg, // Config byte 1
    output logic [7:0]       o_entry_frag_cfg, // Config byte 2
    output logic             o_cfg_reject,   // Last config not applied
    output logic             o_rsp_valid,    // Service answer pulse
    output logic [7:0]       o_rsp_status,   // Answer status
    output logic [7:0]       o_rsp_data,     // Get answer value
    output logic [3:0]       o_sw_out        // Switching outputs
);

    ////////////////////////////////////////////////////////////////////
    // Entry output assembly parser
    logic [8:0]  idx_ff,    nxt_idx;
    logic [7:0]  fnum_ff,   nxt_fnum;
    logic [7:0]  frem_ff,   nxt_frem;
    logic [7:0]  fsize_ff,  nxt_fsize;
    logic        ndata_ff,  nxt_ndata;
    logic        tog_ff,    nxt_tog;
    logic        nentry_ff, nxt_nentry;
    logic [15:0] elen_ff,   nxt_elen;
    logic        ev_ff,     nxt_ev;
    logic [7:0]  ed_ff,     nxt_ed;
    logic [7:0]  ei_ff,     nxt_ei;
    logic        ovr_ff,    nxt_ovr;
    logic [8:0]  pos;
    logic [7:0]  ent_frag_ff;
    logic        frag_en;

    // Byte position: a start strobe forces position zero
    always_comb begin
        pos        = i_asm_sof ? '0 : idx_ff;
        frag_en    = ent_frag_ff[fieldbus_assembly_io_map_pkg::CFG_EN_BIT];
        nxt_idx    = idx_ff;
        nxt_fnum   = fnum_ff;
        nxt_frem   = frem_ff;
        nxt_fsize  = fsize_ff;
        nxt_ndata  = ndata_ff;
        nxt_tog    = tog_ff;
        nxt_nentry = 1'b0;
        nxt_elen   = elen_ff;
        nxt_ev     = 1'b0;
        nxt_ed     = ed_ff;
        nxt_ei     = ei_ff;
        nxt_ovr    = i_asm_valid && i_asm_sof ? 1'b0 : ovr_ff;
        if (i_asm_valid) begin
            if (pos >= fieldbus_assembly_io_map_pkg::ASM_MAX_LEN) begin
                nxt_ovr = 1'b1;
            end else begin
                nxt_idx = pos + 9'h001;
                // Fragment fields only mean something with entry fragmentation on
                if (pos == fieldbus_assembly_io_map_pkg::ASM_FRAG_NUM) begin
                    if (frag_en) nxt_fnum = i_asm_byte;
                end else if (pos == fieldbus_assembly_io_map_pkg::ASM_FRAG_REM) begin
                    if (frag_en) nxt_frem = i_asm_byte;
                end else if (pos == fieldbus_assembly_io_map_pkg::ASM_FRAG_SIZE) begin
                    if (frag_en) nxt_fsize = i_asm_byte;
                end else if (pos == fieldbus_assembly_io_map_pkg::ASM_FLAGS) begin
                    // Toggle is edge significant: any change is one new entry
                    nxt_ndata  = i_asm_byte[fieldbus_assembly_io_map_pkg::FLAG_NEW_DATA];
                    nxt_tog    = i_asm_byte[fieldbus_assembly_io_map_pkg::FLAG_NEW_ENTRY];
                    nxt_nentry = nxt_tog != tog_ff;
                end else if (pos == fieldbus_assembly_io_map_pkg::ASM_LEN_LO) begin
                    nxt_elen = {elen_ff[15:8], i_asm_byte};
                end else if (pos == fieldbus_assembly_io_map_pkg::ASM_LEN_HI) begin
                    nxt_elen = {i_asm_byte, elen_ff[7:0]};
                end else begin
                    // Payload count is however many bytes the controller sends; the length field is not checked
                    nxt_ev = 1'b1;
                    nxt_ed = i_asm_byte;
                    nxt_ei = 8'(pos - fieldbus_assembly_io_map_pkg::ASM_PAYLOAD);
                end
            end
        end
    end

    // Parser state registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            {idx_ff, fnum_ff, frem_ff, fsize_ff, ndata_ff, tog_ff, nentry_ff} <= '0;
            {elen_ff, ev_ff, ed_ff, ei_ff, ovr_ff} <= '0;
        end else begin
            {idx_ff, fnum_ff, frem_ff, fsize_ff, ndata_ff, tog_ff, nentry_ff} <=
                {nxt_idx, nxt_fnum, nxt_frem, nxt_fsize, nxt_ndata, nxt_tog, nxt_nentry};
            {elen_ff, ev_ff, ed_ff, ei_ff, ovr_ff} <=
                {nxt_elen, nxt_ev, nxt_ed, nxt_ei, nxt_ovr};
        end
    end

    assign o_frag_num    = fnum_ff;
    assign o_frag_remain = frem_ff;
    assign o_frag_size   = fsize_ff;
    assign o_new_data    = ndata_ff;
    assign o_new_entry   = nentry_ff;
    assign o_entry_len   = elen_ff;
    assign o_entry_valid = ev_ff;
    assign o_entry_data  = ed_ff;
    assign o_entry_index = ei_ff;
    assign o_asm_overrun = ovr_ff;

    ////////////////////////////////////////////////////////////////////
    // Configuration assembly capture
    logic [1:0] cidx_ff,  nxt_cidx;
    logic       cbad_ff,  nxt_cbad;
    logic [7:0] sh0_ff,   nxt_sh0;
    logic [7:0] sh1_ff,   nxt_sh1;
    logic [7:0] hs_ff,    nxt_hs;
    logic [7:0] rf_ff,    nxt_rf;
    logic [7:0] nxt_ef;
    logic       rej_ff,   nxt_rej;
    logic [1:0] cpos;

    // Bytes land in shadows; the set is applied only when exactly
    // three arrive, so a short or long transfer never half-applies
    always_comb begin
        cpos     = i_cfg_sof ? '0 : cidx_ff;
        nxt_cidx = cidx_ff;
        nxt_cbad = cbad_ff;
        nxt_sh0  = sh0_ff;
        nxt_sh1  = sh1_ff;
        nxt_hs   = hs_ff;
        nxt_rf   = rf_ff;
        nxt_ef   = ent_frag_ff;
        nxt_rej  = rej_ff;
        if (i_cfg_valid && i_conn_setup) begin
            if (i_cfg_sof) begin
                nxt_cbad = 1'b0;
            end
            if (cpos == fieldbus_assembly_io_map_pkg::CFG_HANDSHAKE) begin
                nxt_sh0 = i_cfg_byte;
            end else if (cpos == fieldbus_assembly_io_map_pkg::CFG_RES_FRAG) begin
                nxt_sh1 = i_cfg_byte;
            end
            if (cpos > fieldbus_assembly_io_map_pkg::CFG_ENT_FRAG) begin
                nxt_cbad = 1'b1;
            end else begin
                nxt_cidx = cpos + 2'h1;
            end
            if (i_cfg_last) begin
                nxt_cidx = '0;
                if (cpos == fieldbus_assembly_io_map_pkg::CFG_ENT_FRAG
                    && !(nxt_cbad && !i_cfg_sof)) begin
                    nxt_hs  = nxt_sh0;
                    nxt_rf  = nxt_sh1;
                    nxt_ef  = i_cfg_byte;
                    nxt_rej = 1'b0;
                end else begin
                    nxt_rej = 1'b1;
                end
            end
        end
    end

    // Configuration registers, all zero after reset
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            {cidx_ff, cbad_ff, rej_ff} <= '0;
            sh0_ff      <= fieldbus_assembly_io_map_pkg::CFG_RESET;
            sh1_ff      <= fieldbus_assembly_io_map_pkg::CFG_RESET;
            hs_ff       <= fieldbus_assembly_io_map_pkg::CFG_RESET;
            rf_ff       <= fieldbus_assembly_io_map_pkg::CFG_RESET;
            ent_frag_ff <= fieldbus_assembly_io_map_pkg::CFG_RESET;
        end else begin
            {cidx_ff, cbad_ff, rej_ff} <= {nxt_cidx, nxt_cbad, nxt_rej};
            sh0_ff      <= nxt_sh0;
            sh1_ff      <= nxt_sh1;
            hs_ff       <= nxt_hs;
            rf_ff       <= nxt_rf;
            ent_frag_ff <= nxt_ef;
        end
    end

    assign o_handshake_cfg   = hs_ff;
    assign o_result_frag_cfg = rf_ff;
    assign o_entry_frag_cfg  = ent_frag_ff;
    assign o_cfg_reject      = rej_ff;

    ////////////////////////////////////////////////////////////////////
    // Switching object service decode
    logic [3:0] act_ff, crst_ff, cmp_ff, ctog_ff;
    logic [3:0] set_act, set_rst;
    logic       rv_ff,  nxt_rv;
    logic [7:0] rs_ff,  nxt_rs;
    logic [7:0] rd_ff,  nxt_rd;
    logic [1:0] ch;

    // One answer per request, one cycle after it is taken
    always_comb begin
        ch      = 2'(i_req_inst - fieldbus_assembly_io_map_pkg::INST_FIRST);
        set_act = '0;
        set_rst = '0;
        nxt_rv  = i_req_valid;
        nxt_rs  = fieldbus_assembly_io_map_pkg::ST_OK;
        nxt_rd  = '0;
        if (!i_req_valid) begin
            nxt_rs = rs_ff;
            nxt_rd = rd_ff;
        end else if (i_req_class != fieldbus_assembly_io_map_pkg::SW_CLASS) begin
            nxt_rs = fieldbus_assembly_io_map_pkg::ST_NO_PATH;
        end else if (i_req_service != fieldbus_assembly_io_map_pkg::SVC_GET
                     && i_req_service != fieldbus_assembly_io_map_pkg::SVC_SET) begin
            nxt_rs = fieldbus_assembly_io_map_pkg::ST_NO_SVC;
        end else if (i_req_inst < fieldbus_assembly_io_map_pkg::INST_FIRST
                     || i_req_inst > fieldbus_assembly_io_map_pkg::INST_LAST) begin
            nxt_rs = fieldbus_assembly_io_map_pkg::ST_NO_INST;
        end else if (i_req_attr < fieldbus_assembly_io_map_pkg::ATTR_STATUS
                     || i_req_attr > fieldbus_assembly_io_map_pkg::ATTR_CMP_TOG) begin
            nxt_rs = fieldbus_assembly_io_map_pkg::ST_NO_ATTR;
        end else if (i_req_service == fieldbus_assembly_io_map_pkg::SVC_SET) begin
            // Only attributes 6 and 7 are settable, and only to 0 or 1
            if (i_req_attr != fieldbus_assembly_io_map_pkg::ATTR_OUT_ACT
                && i_req_attr != fieldbus_assembly_io_map_pkg::ATTR_CNT_RST) begin
                nxt_rs = fieldbus_assembly_io_map_pkg::ST_NOT_SET;
            end else if (i_req_wdata[7:1] != 7'h00) begin
                nxt_rs = fieldbus_assembly_io_map_pkg::ST_BAD_VALUE;
            end else if (i_req_attr == fieldbus_assembly_io_map_pkg::ATTR_OUT_ACT) begin
                set_act[ch] = 1'b1;
            end else begin
                set_rst[ch] = 1'b1;
            end
        end else if (i_req_attr == fieldbus_assembly_io_map_pkg::ATTR_STATUS) begin
            nxt_rd = {7'h00, i_sw_state[ch]};
        end else if (i_req_attr == fieldbus_assembly_io_map_pkg::ATTR_OUT_ACT) begin
            nxt_rd = {7'h00, act_ff[ch]};
        end else if (i_req_attr == fieldbus_assembly_io_map_pkg::ATTR_CNT_RST) begin
            nxt_rd = {7'h00, crst_ff[ch]};
        end else if (i_req_attr == fieldbus_assembly_io_map_pkg::ATTR_CMP) begin
            nxt_rd = {7'h00, cmp_ff[ch]};
        end else begin
            nxt_rd = {7'h00, ctog_ff[ch]};
        end
    end

    // Answer registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rv_ff <= 1'b0;
            rs_ff <= fieldbus_assembly_io_map_pkg::ST_OK;
            rd_ff <= '0;
        end else begin
            rv_ff <= nxt_rv;
            rs_ff <= nxt_rs;
            rd_ff <= nxt_rd;
        end
    end

    assign o_rsp_valid  = rv_ff;
    assign o_rsp_status = rs_ff;
    assign o_rsp_data   = rd_ff;
    assign o_sw_out     = act_ff;

    ////////////////////////////////////////////////////////////////////
    // Per channel output, event counter and comparison flags
    for (genvar g = 0; g < fieldbus_assembly_io_map_pkg::NUM_CH; g++) begin : g_ch
        logic [15:0] cnt_ff, nxt_cnt;
        logic        nxt_act, nxt_crst, nxt_cmp, nxt_ctog, over;

        // Counter saturates rather than wrapping so a long run never
        // falsely drops the exceeded flag
        always_comb begin
            nxt_act  = set_act[g] ? i_req_wdata[0] : act_ff[g];
            nxt_crst = set_rst[g] ? i_req_wdata[0] : crst_ff[g];
            nxt_cnt  = cnt_ff;
            nxt_cmp  = cmp_ff[g];
            nxt_ctog = ctog_ff[g];
            over     = 1'b0;
            if (nxt_crst && !crst_ff[g]) begin
                nxt_cnt  = '0;
                nxt_cmp  = 1'b0;
                nxt_ctog = 1'b0;
            end else if (i_sw_event[g]) begin
                if (cnt_ff != fieldbus_assembly_io_map_pkg::CNT_MAX) begin
                    nxt_cnt = cnt_ff + 16'h0001;
                end
                over = nxt_cnt > i_cmp_value;
                if (over) begin
                    nxt_cmp = 1'b1;
                    if (i_multi_mode[g]) begin
                        // Restart counting so the next exceed is seen again
                        nxt_ctog = !ctog_ff[g];
                        nxt_cnt  = '0;
                    end
                end
            end
        end

        // Channel registers
        always_ff @(posedge i_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                cnt_ff     <= '0;
                act_ff[g]  <= 1'b0;
                crst_ff[g] <= 1'b0;
                cmp_ff[g]  <= 1'b0;
                ctog_ff[g] <= 1'b0;
            end else begin
                cnt_ff     <= nxt_cnt;
                act_ff[g]  <= nxt_act;
                crst_ff[g] <= nxt_crst;
                cmp_ff[g]  <= nxt_cmp;
                ctog_ff[g] <= nxt_ctog;
            end
        end
    end

endmodule
`default_nettype wire

// file: design/fieldbus_assembly_io_map_pkg.sv
// Constants for the assembly and switching channel mapping block
// Summary of operation
// - Accept entry assembly from 1 to 261 bytes
// - Bytes 0-2: fragment number, remaining, size
// - Byte 3: new-data bit 0, new-entry toggle
// - Entry payload starts at byte 6
// - Configuration assembly is exactly three bytes
// - Configuration sent once at setup, then applied
// - Config byte 0 bit 0: result handshake mode
// - Config byte 1 bit 0: result fragmentation
// - Config byte 2 bit 0: entry fragmentation
// - Config bytes reset 0x00; bits 7:1 unused
// - Switching object answers at class 0x67
// - Get single 0x0E, set single 0x10
// - Four channels, attributes 5 to 9, one bit
// - Output activation drives switching output level
// - Reset counter attribute rising edge clears counter
// - Compare flag set when counter exceeds value
// - Multi-switch mode toggles bit each new exceed
`default_nettype none
package fieldbus_assembly_io_map_pkg;
    // Entry output assembly layout
    localparam logic [8:0] ASM_MAX_LEN   = 9'h105; // 261 bytes
    localparam logic [8:0] ASM_FRAG_NUM  = 9'h000;
    localparam logic [8:0] ASM_FRAG_REM  = 9'h001;
    localparam logic [8:0] ASM_FRAG_SIZE = 9'h002;
    localparam logic [8:0] ASM_FLAGS     = 9'h003;
    localparam logic [8:0] ASM_LEN_LO    = 9'h004;
    localparam logic [8:0] ASM_LEN_HI    = 9'h005;
    localparam logic [8:0] ASM_PAYLOAD   = 9'h006;
    localparam int         FLAG_NEW_DATA = 0;
    localparam int         FLAG_NEW_ENTRY = 1;
    // Configuration assembly
    localparam logic [1:0] CFG_HANDSHAKE = 2'h0;
    localparam logic [1:0] CFG_RES_FRAG  = 2'h1;
    localparam logic [1:0] CFG_ENT_FRAG  = 2'h2;
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam int         CFG_EN_BIT    = 0;
    // Switching object
    localparam logic [7:0] SW_CLASS      = 8'h67;
    localparam logic [7:0] SVC_GET       = 8'h0E;
    localparam logic [7:0] SVC_SET       = 8'h10;
    localparam int         NUM_CH        = 4;
    localparam logic [7:0] ATTR_STATUS   = 8'h05;
    localparam logic [7:0] ATTR_OUT_ACT  = 8'h06;
    localparam logic [7:0] ATTR_CNT_RST  = 8'h07;
    localparam logic [7:0] ATTR_CMP      = 8'h08;
    localparam logic [7:0] ATTR_CMP_TOG  = 8'h09;
    localparam logic [7:0] INST_FIRST    = 8'h01;
    localparam logic [7:0] INST_LAST     = 8'h04;
    // Answer status codes
    localparam logic [7:0] ST_OK         = 8'h00;
    localparam logic [7:0] ST_NO_PATH    = 8'h05;
    localparam logic [7:0] ST_NO_SVC     = 8'h08;
    localparam logic [7:0] ST_BAD_VALUE  = 8'h09;
    localparam logic [7:0] ST_NOT_SET    = 8'h0E;
    localparam logic [7:0] ST_NO_ATTR    = 8'h14;
    localparam logic [7:0] ST_NO_INST    = 8'h16;
    localparam logic [15:0] CNT_MAX      = 16'hFFFF;
endpackage
`default_nettype wire

// file: tb/fieldbus_assembly_io_map_assertions.sv
// Concurrent checks on the ports of the assembly mapping block
`default_nettype none
module fieldbus_assembly_io_map_assertions (
    // Watched ports
    input wire logic       i_clk, i_rstn, i_req_valid, i_asm_valid, i_asm_sof,
    input wire logic       i_cfg_valid, i_cfg_sof, i_cfg_last, i_conn_setup,
    input wire logic [7:0] i_req_service, i_req_class, i_req_inst, i_req_attr,
    input wire logic [7:0] i_req_wdata, i_asm_byte, i_cfg_byte, o_frag_num,
    input wire logic [7:0] o_handshake_cfg, o_result_frag_cfg, o_entry_frag_cfg,
    input wire logic       o_cfg_reject, o_rsp_valid,
    input wire logic [7:0] o_rsp_status,
    input wire logic [3:0] o_sw_out
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic req_sw;
    logic inst_ok;
    // Request aimed at the switching object, instance in range
    assign req_sw  = i_req_valid && i_req_class == 8'h67;
    assign inst_ok = i_req_inst >= 8'h01 && i_req_inst <= 8'h04;
    ////////////////////////////////////////////////////////////////////////////////
    // Full and one-short config transfers
    sequence s_cfg_three;
        i_cfg_valid && i_conn_setup && i_cfg_sof && !i_cfg_last ##1
        i_cfg_valid && i_conn_setup && !i_cfg_sof && !i_cfg_last ##1
        i_cfg_valid && i_conn_setup && !i_cfg_sof && i_cfg_last;
    endsequence
    sequence s_cfg_two;
        i_cfg_valid && i_conn_setup && i_cfg_sof && !i_cfg_last ##1
        i_cfg_valid && i_conn_setup && !i_cfg_sof && i_cfg_last;
    endsequence
    a_cfg_apply: assert property (s_cfg_three |=> !o_cfg_reject
        && o_handshake_cfg == $past(i_cfg_byte, 3)
        && o_result_frag_cfg == $past(i_cfg_byte, 2)
        && o_entry_frag_cfg == $past(i_cfg_byte)) else $error("config not applied");
    a_cfg_short: assert property (s_cfg_two |=> o_cfg_reject)
        else $error("short config accepted");
    a_cfg_hold: assert property (!i_cfg_valid |=> $stable(o_handshake_cfg)
        && $stable(o_result_frag_cfg) && $stable(o_entry_frag_cfg))
        else $error("config changed without a transfer");
    a_rsp_pulse: assert property (i_req_valid |=> o_rsp_valid)
        else $error("no answer one cycle after request");
    a_rsp_quiet: assert property (!i_req_valid |=> !o_rsp_valid)
        else $error("answer without request");
    a_bad_class: assert property (i_req_valid && !req_sw |=> o_rsp_status == 8'h05)
        else $error("foreign class not refused");
    a_bad_inst: assert property (req_sw && i_req_service == 8'h0E && !inst_ok
        |=> o_rsp_status == 8'h16) else $error("bad instance not refused");
    a_set_out: assert property (req_sw && i_req_service == 8'h10 && inst_ok
        && i_req_attr == 8'h06 && i_req_wdata <= 8'h01
        |=> o_sw_out[$past(i_req_inst[1:0]) - 2'h1] == $past(i_req_wdata[0]))
        else $error("output activation not applied");
    a_frag_num: assert property (i_asm_valid && i_asm_sof && o_entry_frag_cfg[0]
        |=> o_frag_num == $past(i_asm_byte)) else $error("fragment number not taken");
    a_frag_hold: assert property (!o_entry_frag_cfg[0] |=> $stable(o_frag_num))
        else $error("fragment number moved while disabled");
endmodule
`default_nettype wire

// file: tb/scanner_model.sv
// Controller-side model that sends entry output assembly frames
`default_nettype none
module scanner_model (
    input  wire logic  i_clk,   // System clock
    output logic       o_valid, // Byte strobe
    output logic       o_sof,   // First byte marker
    output logic [7:0] o_byte   // Assembly byte
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {o_valid, o_sof, o_byte} = '0;
    // Six header bytes then len payload; released byte inverted
    task automatic send_frame(input logic [7:0] frag, input logic [7:0] flags,
                              input logic [15:0] len);
        logic [7:0] b;
        for (int k = 0; k < 6 + len; k++) begin
            case (k)
                0: b = frag;
                1: b = 8'h02;
                2: b = 8'h20;
                3: b = flags;
                4: b = len[7:0];
                5: b = len[15:8];
                default: b = 8'hA0 + 8'(k - 6);
            endcase
            @(negedge i_clk);
            o_valid = 1'b1;
            o_sof   = (k == 0);
            o_byte  = b;
        end
        @(negedge i_clk);
        o_valid = 1'b0;
        o_byte  = ~o_byte;
    endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the assembly and switching channel block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk, i_rstn, i_cfg_valid, i_cfg_sof, i_cfg_last, i_conn_setup;
    logic        i_req_valid, i_asm_valid, i_asm_sof, o_new_data, o_new_entry;
    logic        o_entry_valid, o_asm_overrun, o_cfg_reject, o_rsp_valid;
    logic [7:0]  i_cfg_byte, i_req_service, i_req_class, i_req_inst, i_req_attr;
    logic [7:0]  i_req_wdata, i_asm_byte, o_frag_num, o_frag_remain, o_frag_size;
    logic [7:0]  o_entry_data, o_entry_index, o_handshake_cfg, o_result_frag_cfg;
    logic [7:0]  o_entry_frag_cfg, o_rsp_status, o_rsp_data, first_byte = '0;
    logic [3:0]  i_sw_state, i_sw_event, i_multi_mode, o_sw_out;
    logic [15:0] i_cmp_value, o_entry_len, n_entry = '0, n_tog = '0;
    int          failures, checks;
    fieldbus_assembly_io_map u_dut (.*);
    scanner_model u_host (.i_clk, .o_valid(i_asm_valid), .o_sof(i_asm_sof),
        .o_byte(i_asm_byte));
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    // Count one-cycle strobes as they pass
    always @(posedge i_clk) begin
        if (o_entry_valid) n_entry <= n_entry + 16'h0001;
        if (o_new_entry) n_tog <= n_tog + 16'h0001;
        if (o_entry_valid && o_entry_index == 8'h00) first_byte <= o_entry_data;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // One request held for one edge; answer due next cycle
    task automatic rq(input logic [39:0] r);
        @(negedge i_clk);
        i_req_valid = 1'b1;
        {i_req_service, i_req_class, i_req_inst, i_req_attr, i_req_wdata} = r;
        @(negedge i_clk);
        i_req_valid = 1'b0;
        chk(o_rsp_valid, 16'h0001);
    endtask
    task automatic cfg(input logic [23:0] b, input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge i_clk);
            i_cfg_valid = 1'b1;
            i_cfg_sof   = (k == 0);
            i_cfg_last  = (k == n - 1);
            i_cfg_byte  = b[8*k +: 8];
        end
        @(negedge i_clk);
        i_cfg_valid = 1'b0;
    endtask
    task automatic ev(input logic [3:0] m, input int n);
        repeat (n) begin
            @(negedge i_clk);
            i_sw_event = m;
            @(negedge i_clk);
            i_sw_event = 4'h0;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_config();
        chk({o_handshake_cfg, o_result_frag_cfg}, 16'h0000);
        chk({o_entry_frag_cfg, 4'h0, o_sw_out}, 16'h0000);
        i_conn_setup = 1'b1;
        cfg(24'h010100, 3);
        chk({o_handshake_cfg, o_result_frag_cfg}, 16'h0001);
        chk({o_entry_frag_cfg, 7'h00, o_cfg_reject}, 16'h0100);
        cfg(24'h000001, 2);
        chk({o_handshake_cfg, 7'h00, o_cfg_reject}, 16'h0001);
        i_conn_setup = 1'b0;
        cfg(24'h000001, 3);
        chk({o_handshake_cfg, o_entry_frag_cfg}, 16'h0001);
        $display("t_config done");
    endtask
    task automatic t_frame();
        u_host.send_frame(8'h03, 8'h03, 16'h0005);
        repeat (2) @(negedge i_clk);
        chk({o_frag_num, o_frag_remain}, 16'h0302);
        chk({o_frag_size, 7'h00, o_new_data}, 16'h2001);
        chk(o_entry_len, 16'h0005);
        chk({first_byte, n_entry[7:0]}, 16'hA005);
        u_host.send_frame(8'h07, 8'h00, 16'h00FF);
        repeat (2) @(negedge i_clk);
        chk({7'h00, o_asm_overrun, n_entry[7:0]}, 16'h0004);
        u_host.send_frame(8'h08, 8'h00, 16'h0100);
        repeat (2) @(negedge i_clk);
        chk({7'h00, o_asm_overrun, 7'h00, o_new_data}, 16'h0100);
        chk(n_tog, 16'h0002);
        $display("t_frame done");
    endtask
    task automatic t_service();
        logic [39:0] bad [6];
        logic [7:0]  st [6];
        bad = '{40'h0E66010500, 40'h0167010500, 40'h0E67050500, 40'h0E67010400,
                40'h1067010501, 40'h1067010602};
        st  = '{8'h05, 8'h08, 8'h16, 8'h14, 8'h0E, 8'h09};
        for (int c = 0; c < 4; c++) begin
            rq({16'h1067, 8'(c + 1), 16'h0601});
            chk({o_rsp_status, 4'h0, o_sw_out}, 16'(2 ** (c + 1) - 1));
        end
        rq(40'h1067020600);
        chk(o_sw_out, 16'h000D);
        i_sw_state = 4'h4;
        rq(40'h0E67030500);
        chk({o_rsp_status, o_rsp_data}, 16'h0001);
        for (int e = 0; e < 6; e++) begin
            rq(bad[e]);
            chk({o_rsp_status, o_rsp_data}, {st[e], 8'h00});
        end
        chk(o_sw_out, 16'h000D);
        $display("t_service done");
    endtask
    task automatic t_counter();
        i_cmp_value  = 16'h0002;
        i_multi_mode = 4'h2;
        ev(4'h3, 2);
        rq(40'h0E67010800);
        chk(o_rsp_data, 16'h0000);
        ev(4'h3, 1);
        rq(40'h0E67010800);
        chk(o_rsp_data, 16'h0001);
        rq(40'h0E67020900);
        chk(o_rsp_data, 16'h0001);
        ev(4'h3, 3);
        rq(40'h0E67020900);
        chk(o_rsp_data, 16'h0000);
        rq(40'h1067010701);
        rq(40'h0E67010800);
        chk(o_rsp_data, 16'h0000);
        $display("t_counter done");
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        {i_rstn, i_cfg_valid, i_cfg_sof, i_cfg_last, i_conn_setup, i_req_valid} = '0;
        {i_cfg_byte, i_req_service, i_req_class, i_req_inst, i_req_attr} = '0;
        {i_req_wdata, i_sw_state, i_sw_event, i_multi_mode, i_cmp_value} = '0;
        {failures, checks} = '0;
        repeat (8) @(negedge i_clk);
        i_rstn = 1'b1;
        t_config();
        t_frame();
        t_service();
        t_counter();
        tally_and_finish();
    end
    // Cuts a hang short
    initial begin
        repeat (50000) @(posedge i_clk);
        failures++;
        tally_and_finish();
    end
endmodule
bind fieldbus_assembly_io_map fieldbus_assembly_io_map_assertions u_chk (.*);
`default_nettype wire
